// ### logic/sgp_cfg.svh
// register map, field positions, reset values and timing constants
`ifndef SGP_CFG_SVH
`define SGP_CFG_SVH

// register indices; byte address is four times the index
`define SGP_IDX_TRL         6'h0c
`define SGP_IDX_TEST        6'h0d
`define SGP_IDX_PWR         6'h0e
`define SGP_IDX_DWELL       6'h0f

// field positions
`define SGP_TRL_EN_BIT      1
`define SGP_PASS_BIT        0
`define SGP_PLL_BIT         5
`define SGP_MODE_MSB        4
`define SGP_MODE_LSB        3

// reset and fixed read values
`define SGP_TRL_RSV_VAL     6'h11
`define SGP_TEST_VAL        8'h00
`define SGP_DWELL_RST       8'h50
`define SGP_MODE_RST        2'h0

// power mode codes
`define SGP_MODE_NORMAL     2'h0
`define SGP_MODE_ED         2'h1
`define SGP_MODE_SOFT       2'h2

// egress port that carries the trailer byte
`define SGP_TAG_PORT        3'h5

// dwell unit in ms, clock in MHz, and the derived cycles per unit
`define SGP_TICK_MS         20
`define SGP_CLK_MHZ         250
`define SGP_TICK_CYCLES     ((`SGP_TICK_MS) * (`SGP_CLK_MHZ) * 1000)

`endif

// ### logic/sgp_pkg.sv
// shared types for the global control and power registers
package sgp_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sgp_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sgp_apb_rsp_t;

  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic       fcs_first;
    logic       is_pause;
    logic [2:0] port;
    logic [7:0] tag;
    logic [7:0] data;
  } sgp_byte_t;

  typedef enum logic [1:0] {normal_power_state, energy_detect_state,
                            soft_powerdown_state} sgp_pwr_t;
  typedef enum logic [2:0] {sel_none, sel_trl, sel_test, sel_pwr, sel_dwell} sgp_sel_t;
  typedef enum logic [1:0] {tm_idle, tm_count, tm_sleep} sgp_tm_t;

endpackage

// ### logic/sgp_sleep_timer.sv
// no-energy dwell timer that decides entry to the low-power state
`timescale 1ns/1ns
`default_nettype none
`include "sgp_cfg.svh"
module sgp_sleep_timer
  import sgp_pkg::*;
#(
  parameter int TICK_CYCLES = `SGP_TICK_CYCLES
)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // control
  input  wire logic       ed_mode,
  input  wire logic       no_energy,
  input  wire logic [7:0] dwell,
  // status
  output logic            low_power
);

  typedef struct packed {
    sgp_tm_t     phase;
    logic [22:0] tick_cnt;
    logic [7:0]  ticks;
    logic        low_power;
  } sgp_tm_st_t;

  sgp_tm_st_t st;
  sgp_tm_st_t next_st;

  always_comb
  begin
    next_st = st;
    if (!ed_mode || !no_energy)
    begin
      next_st = '0;
      next_st.phase = tm_idle;
    end
    else if (st.ticks >= dwell)
    begin
      next_st.phase = tm_sleep;
      next_st.low_power = 1'b1;
    end
    else
    begin
      next_st.phase = tm_count;
      if (st.tick_cnt == 23'(TICK_CYCLES - 1))
      begin
        next_st.tick_cnt = '0;
        next_st.ticks = st.ticks + 8'h01;
      end
      else
        next_st.tick_cnt = st.tick_cnt + 23'h00_0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.phase <= tm_idle;
    end
    else
      st <= next_st;
  end

  assign low_power = st.low_power;

  a_sleep_needs_dwell: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(st.low_power) |-> $past(st.ticks) >= $past(dwell) && $past(no_energy))
    else $error("low-power state entered before the dwell ran out");
  a_wake_on_energy: assert property (@(posedge clk) disable iff (sys_rst)
    (!ed_mode || !no_energy) |=> !st.low_power && st.ticks == 8'h00)
    else $error("low-power state held without energy-detect idle");

endmodule
`default_nettype wire

// ### logic/sgp_egress_tag.sv
// egress byte path: trailer byte ahead of the fcs and pause frame filter
`timescale 1ns/1ns
`default_nettype none
`include "sgp_cfg.svh"
module sgp_egress_tag
  import sgp_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      sys_rst,
  // control
  input  wire logic      trl_en,
  input  wire logic      pass_pause,
  // byte stream
  input  wire sgp_byte_t in_byte,
  output logic           in_ready,
  output sgp_byte_t      out_byte
);

  typedef struct packed {
    logic      tag_on;
    logic      drop;
    logic      ready;
    logic      pend_valid;
    sgp_byte_t pend;
    sgp_byte_t out;
  } sgp_tag_st_t;

  sgp_tag_st_t st;
  sgp_tag_st_t next_st;
  logic        take;
  logic        frm_tag;
  logic        frm_drop;

  always_comb
  begin
    next_st = st;
    take = in_byte.valid && st.ready;
    // frame attributes are latched from the first byte
    frm_tag = in_byte.sof ? (trl_en && in_byte.port == `SGP_TAG_PORT) : st.tag_on;
    frm_drop = in_byte.sof ? (in_byte.is_pause && !pass_pause) : st.drop;
    next_st.out = '0;
    next_st.ready = 1'b1;
    next_st.pend_valid = 1'b0;
    if (st.pend_valid)
      next_st.out = st.pend;
    else if (take)
    begin
      next_st.tag_on = frm_tag;
      next_st.drop = frm_drop;
      if (!frm_drop)
      begin
        next_st.out = in_byte;
        if (in_byte.fcs_first && frm_tag)
        begin
          // one trailer byte goes out, the fcs byte waits a cycle
          next_st.out.data = in_byte.tag;
          next_st.out.fcs_first = 1'b0;
          next_st.out.eof = 1'b0;
          next_st.pend = in_byte;
          next_st.pend_valid = 1'b1;
          next_st.ready = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign in_ready = st.ready;
  assign out_byte = st.out;

  sequence s_trailer_then_fcs(logic [7:0] t, logic [7:0] d);
    out_byte.valid && !out_byte.fcs_first && out_byte.data == t
    ##1 out_byte.valid && out_byte.fcs_first && out_byte.data == d;
  endsequence
  sequence s_fcs_tagged;
    take && in_byte.fcs_first && frm_tag && !frm_drop;
  endsequence

  // tag and fcs byte are held in locals: the input may move on after the take
  property p_trailer_one_byte;
    logic [7:0] t;
    logic [7:0] d;
    (s_fcs_tagged, t = in_byte.tag, d = in_byte.data) |=> s_trailer_then_fcs(t, d);
  endproperty

  a_trailer_one_byte: assert property (@(posedge clk) disable iff (sys_rst) p_trailer_one_byte)
    else $error("trailer byte not inserted once before the fcs");
  a_untagged_fcs: assert property (@(posedge clk) disable iff (sys_rst)
    take && in_byte.fcs_first && !frm_tag && !frm_drop |=> out_byte.fcs_first)
    else $error("byte inserted on a frame without the trailer");
  a_pause_dropped: assert property (@(posedge clk) disable iff (sys_rst)
    take && frm_drop |=> !out_byte.valid)
    else $error("filtered pause frame byte passed");

endmodule
`default_nettype wire

// ### logic/sgp_regs.sv
// global trailer, pause and power-down control registers with apb slave
`timescale 1ns/1ns
`default_nettype none
`include "sgp_cfg.svh"
module sgp_regs
  import sgp_pkg::*;
#(
  parameter int TICK_CYCLES = `SGP_TICK_CYCLES
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // apb register port
  input  wire sgp_apb_req_t apb_req,
  output sgp_apb_rsp_t      apb_rsp,
  // phy energy indication, asynchronous
  input  wire logic         energy_present,
  // power outputs
  output sgp_pwr_t          power_state,
  output logic              energy_detect_low_power,
  output logic              pll_powerdown,
  // egress byte stream
  input  wire sgp_byte_t    in_byte,
  output logic              in_ready,
  output sgp_byte_t         out_byte
);

  typedef struct packed {
    logic         trl_en;
    logic         pass_pause;
    logic         pll_en;
    logic [1:0]   mode;
    logic [7:0]   dwell;
    sgp_apb_rsp_t rsp;
    logic [1:0]   sync;
    sgp_pwr_t     pwr;
    logic         pll_pd;
  } sgp_top_st_t;

  sgp_top_st_t st;
  sgp_top_st_t next_st;
  logic        setup;
  logic        done;
  sgp_sel_t    sel;
  logic        tmr_low;

  function automatic sgp_sel_t sgp_decode(input logic [7:0] addr);
    sgp_sel_t s;
    s = sel_none;
    if (addr[1:0] == 2'h0)
    begin
      unique case (addr[7:2])
        `SGP_IDX_TRL:   s = sel_trl;
        `SGP_IDX_TEST:  s = sel_test;
        `SGP_IDX_PWR:   s = sel_pwr;
        `SGP_IDX_DWELL: s = sel_dwell;
        default:        s = sel_none;
      endcase
    end
    return s;
  endfunction

  function automatic logic [7:0] sgp_read(input sgp_sel_t s, input sgp_top_st_t r);
    logic [7:0] v;
    v = 8'h00;
    unique case (s)
      sel_trl:
      begin
        v = {`SGP_TRL_RSV_VAL, 2'h0};
        v[`SGP_TRL_EN_BIT] = r.trl_en;
        v[`SGP_PASS_BIT] = r.pass_pause;
      end
      sel_test:  v = `SGP_TEST_VAL;
      sel_pwr:
      begin
        v[`SGP_PLL_BIT] = r.pll_en;
        v[`SGP_MODE_MSB:`SGP_MODE_LSB] = r.mode;
      end
      sel_dwell: v = r.dwell;
      sel_none:  v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb
  begin
    next_st = st;
    setup = apb_req.psel && !apb_req.penable;
    done = apb_req.psel && apb_req.penable && st.rsp.pready;
    sel = sgp_decode(apb_req.paddr);
    next_st.rsp.pready = 1'b0;
    next_st.rsp.pslverr = 1'b0;
    // answer one cycle after setup, data captured from the setup phase
    if (setup)
    begin
      next_st.rsp.pready = 1'b1;
      next_st.rsp.pslverr = (sel == sel_none);
      next_st.rsp.prdata = {24'h00_0000, sgp_read(sel, st)};
    end
    if (done && apb_req.pwrite)
    begin
      // reserved and test bits have no storage, so writes fall away
      unique case (sel)
        sel_trl:
        begin
          next_st.trl_en = apb_req.pwdata[`SGP_TRL_EN_BIT];
          next_st.pass_pause = apb_req.pwdata[`SGP_PASS_BIT];
        end
        sel_pwr:
        begin
          next_st.pll_en = apb_req.pwdata[`SGP_PLL_BIT];
          next_st.mode = apb_req.pwdata[`SGP_MODE_MSB:`SGP_MODE_LSB];
        end
        sel_dwell: next_st.dwell = apb_req.pwdata[7:0];
        sel_test, sel_none:
        begin
          next_st.dwell = st.dwell;
        end
      endcase
    end
    if (done && !apb_req.pwrite && sel == sel_pwr)
      next_st.mode = `SGP_MODE_RST;
    next_st.sync = {st.sync[0], energy_present};
    unique case (st.mode)
      `SGP_MODE_ED:   next_st.pwr = energy_detect_state;
      `SGP_MODE_SOFT: next_st.pwr = soft_powerdown_state;
      default:        next_st.pwr = normal_power_state;
    endcase
    next_st.pll_pd = st.pll_en && tmr_low;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.mode <= `SGP_MODE_RST;
      st.dwell <= `SGP_DWELL_RST;
      st.pwr <= normal_power_state;
    end
    else
      st <= next_st;
  end

  sgp_sleep_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ed_mode   (st.pwr == energy_detect_state),
    .no_energy (!st.sync[1]),
    .dwell     (st.dwell),
    .low_power (tmr_low)
  );

  sgp_egress_tag u_tag (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .trl_en     (st.trl_en),
    .pass_pause (st.pass_pause),
    .in_byte    (in_byte),
    .in_ready   (in_ready),
    .out_byte   (out_byte)
  );

  assign apb_rsp = st.rsp;
  assign power_state = st.pwr;
  assign energy_detect_low_power = tmr_low;
  assign pll_powerdown = st.pll_pd;

  sequence s_setup_of(sgp_sel_t s);
    apb_req.psel && !apb_req.penable && sel == s;
  endsequence
  sequence s_read_done_pwr;
    done && !apb_req.pwrite && sel == sel_pwr;
  endsequence

  a_dwell_reset: assert property (@(posedge clk)
    $past(sys_rst) && !sys_rst |-> st.dwell == `SGP_DWELL_RST && !st.pass_pause)
    else $error("dwell or pass bit wrong after reset");
  a_mode_read_clear: assert property (@(posedge clk) disable iff (sys_rst)
    s_read_done_pwr |=> st.mode == `SGP_MODE_RST ##1 st.pwr == normal_power_state)
    else $error("power mode field not cleared by read");
  a_mode_decode: assert property (@(posedge clk) disable iff (sys_rst)
    st.mode == `SGP_MODE_SOFT |=> st.pwr == soft_powerdown_state)
    else $error("soft power-down code not decoded");
  a_mode_reserved: assert property (@(posedge clk) disable iff (sys_rst)
    st.mode == 2'h3 |=> st.pwr == normal_power_state)
    else $error("reserved mode code left normal operation");
  a_pll_ed_only: assert property (@(posedge clk) disable iff (sys_rst)
    pll_powerdown |-> $past(st.pll_en) && $past(tmr_low) && $past(st.pwr, 2) != normal_power_state)
    else $error("pll powered down outside the energy-detect low-power state");
  a_reserved_fixed: assert property (@(posedge clk) disable iff (sys_rst)
    s_setup_of(sel_trl) |=> apb_rsp.pready && apb_rsp.prdata[7:2] == `SGP_TRL_RSV_VAL
      && apb_rsp.prdata[31:8] == 24'h00_0000)
    else $error("reserved bits of the trailer register read wrong");
  a_test_fixed: assert property (@(posedge clk) disable iff (sys_rst)
    s_setup_of(sel_test) |=> apb_rsp.prdata == 32'h0000_0000 && !apb_rsp.pslverr)
    else $error("factory test register read wrong");
  a_unmapped_err: assert property (@(posedge clk) disable iff (sys_rst)
    s_setup_of(sel_none) |=> apb_rsp.pready && apb_rsp.pslverr ##1 !apb_rsp.pready)
    else $error("unmapped address not answered with an error");

endmodule
`default_nettype wire

// ### verification/sgp_regs_tb_top.sv
// self-checking testbench for the global control and power registers
`timescale 1ns/1ns
`default_nettype none
`include "sgp_cfg.svh"
module sgp_regs_tb_top
  import sgp_pkg::*;
;
  localparam int TK = 4;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic       err;
  } sgp_row_t;
  typedef struct packed {
    logic [7:0] ctl;
    logic [2:0] pt;
    logic       ps;
    logic [2:0] n;
  } sgp_fr_t;
  localparam sgp_row_t ROWS [15] = '{
    '{1'b0, 8'h30, 8'h00, 8'h44, 1'b0}, '{1'b0, 8'h34, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h38, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h3c, 8'h00, 8'h50, 1'b0},
    '{1'b1, 8'h30, 8'hff, 8'h00, 1'b0}, '{1'b0, 8'h30, 8'h00, 8'h47, 1'b0},
    '{1'b1, 8'h34, 8'hff, 8'h00, 1'b0}, '{1'b0, 8'h34, 8'h00, 8'h00, 1'b0},
    '{1'b1, 8'h3c, 8'h03, 8'h00, 1'b0}, '{1'b0, 8'h3c, 8'h00, 8'h03, 1'b0},
    '{1'b1, 8'h38, 8'he7, 8'h00, 1'b0}, '{1'b0, 8'h38, 8'h00, 8'h20, 1'b0},
    '{1'b0, 8'h40, 8'h00, 8'h00, 1'b1}, '{1'b1, 8'h31, 8'hff, 8'h00, 1'b1},
    '{1'b0, 8'h2c, 8'h00, 8'h00, 1'b1}};
  localparam sgp_fr_t FR [7] = '{
    '{8'h02, 3'h5, 1'b0, 3'h5}, '{8'h02, 3'h4, 1'b0, 3'h4}, '{8'h02, 3'h6, 1'b0, 3'h4},
    '{8'h00, 3'h5, 1'b0, 3'h4}, '{8'h00, 3'h3, 1'b1, 3'h0}, '{8'h01, 3'h3, 1'b1, 3'h4},
    '{8'h03, 3'h5, 1'b1, 3'h5}};

  logic         clk;
  logic         sys_rst;
  logic         energy_present;
  sgp_apb_req_t apb_req;
  sgp_apb_rsp_t apb_rsp;
  sgp_pwr_t     power_state;
  logic         energy_detect_low_power;
  logic         pll_powerdown;
  sgp_byte_t    in_byte;
  logic         in_ready;
  sgp_byte_t    out_byte;
  int           miscompares;
  int           n_compared;
  logic [7:0]   got[$];
  logic [31:0]  rd;
  logic         er;

  sgp_regs #(
    .TICK_CYCLES (TK)
  ) uut (
    .clk                     (clk),
    .sys_rst                 (sys_rst),
    .apb_req                 (apb_req),
    .apb_rsp                 (apb_rsp),
    .energy_present          (energy_present),
    .power_state             (power_state),
    .energy_detect_low_power (energy_detect_low_power),
    .pll_powerdown           (pll_powerdown),
    .in_byte                 (in_byte),
    .in_ready                (in_ready),
    .out_byte                (out_byte)
  );

  always #2 clk = ~clk;

  always @(posedge clk)
    if (out_byte.valid === 1'b1)
      got.push_back(out_byte.data);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (apb_rsp.pready !== 1'b1 && n < 20);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  // byte held valid until taken with in_ready high
  task automatic send(input sgp_byte_t b);
    int n;
    n = 0;
    in_byte <= b;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (in_ready !== 1'b1 && n < 20);
  endtask

  task automatic frame(input logic [2:0] pt, input logic ps);
    sgp_byte_t b;
    b = '0;
    b.valid = 1'b1;
    b.port = pt;
    b.is_pause = ps;
    b.tag = 8'h5a;
    for (int k = 0; k < 4; k++)
    begin
      b.sof = (k == 0);
      b.fcs_first = (k == 2);
      b.eof = (k == 3);
      b.data = 8'ha0 + 8'(k);
      send(b);
    end
    in_byte <= '0;
  endtask

  function automatic logic [7:0] exp_byte(input int k, input logic [2:0] n);
    if (n == 3'h5 && k == 2)
      return 8'h5a;
    return 8'ha0 + 8'(k) - 8'((n == 3'h5 && k > 2) ? 1 : 0);
  endfunction

  // optional energy blip first, then count edges until sleep
  task automatic sleep(input logic [7:0] ctl, input logic pll, input logic brk);
    int n;
    n = 0;
    apb(1'b1, 8'h38, {24'h0, ctl}, rd, er);
    @(posedge clk);
    if (brk)
    begin
      energy_present <= 1'b0;
      repeat (10) @(posedge clk);
      chk({31'h0, energy_detect_low_power}, 32'h0);
      energy_present <= 1'b1;
      repeat (4) @(posedge clk);
    end
    energy_present <= 1'b0;
    while (energy_detect_low_power !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= 3 * TK && n <= 3 * TK + 6), 32'h1);
    @(posedge clk);
    chk({31'h0, pll_powerdown}, {31'h0, pll});
    energy_present <= 1'b1;
    repeat (6) @(posedge clk);
    chk({30'h0, energy_detect_low_power, pll_powerdown}, 32'h0);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    energy_present = 1'b1;
    apb_req = '0;
    in_byte = '0;
    miscompares = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (ROWS[i])
    begin
      apb(ROWS[i].wr, ROWS[i].addr, {24'h0, ROWS[i].wdat}, rd, er);
      chk({31'h0, er}, {31'h0, ROWS[i].err});
      if (!ROWS[i].wr)
        chk(rd, {24'h0, ROWS[i].rdat});
      @(posedge clk);
    end
    $display("test register rows done");
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, 8'h38, 32'(m << 3), rd, er);
      repeat (3) @(posedge clk);
      chk(32'(power_state), (m == 3) ? 32'h0 : 32'(m));
      apb(1'b0, 8'h38, 32'h0, rd, er);
      chk(rd, 32'(m << 3));
      repeat (3) @(posedge clk);
      chk(32'(power_state), 32'h0);
    end
    $display("test power modes done");
    sleep(8'h28, 1'b1, 1'b0);
    sleep(8'h08, 1'b0, 1'b1);
    apb(1'b0, 8'h38, 32'h0, rd, er);
    @(posedge clk);
    $display("test sleep timing done");
    foreach (FR[i])
    begin
      apb(1'b1, 8'h30, {24'h0, FR[i].ctl}, rd, er);
      @(posedge clk);
      got.delete();
      frame(FR[i].pt, FR[i].ps);
      repeat (4) @(posedge clk);
      chk(32'(got.size()), {29'h0, FR[i].n});
      for (int k = 0; k < got.size() && k < 5; k++)
        chk({24'h0, got[k]}, {24'h0, exp_byte(k, FR[i].n)});
    end
    $display("test egress frames done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 8'h3c, 32'h0, rd, er);
    chk(rd, 32'h50);
    @(posedge clk);
    apb(1'b0, 8'h30, 32'h0, rd, er);
    chk(rd, 32'h44);
    $display("test second reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
